// ==== rtl/esp_consts.svh ====
// register offsets, field positions and reset values of the shared analog port
`ifndef ESP_CONSTS_SVH
`define ESP_CONSTS_SVH
`define ESP_NUM_PINS 8
`define ESP_DATA_INDEX 12'h441
`define ESP_DATA_ADDR 14'h1104
`define ESP_DIR_ADDR 14'h1108
`define ESP_ASEL_ADDR 14'h110C
`define ESP_DIR_RESET 8'h00
`define ESP_ASEL_RESET 8'h00
`define ESP_ASEL_EN_BIT 3
`define ESP_ASEL_CH_LSB 0
`define ESP_ASEL_CH_MSB 2
`define ESP_ADDR_W 14
`endif

// ==== rtl/esp_pkg.sv ====
// types shared by the shared analog port design
package esp_pkg;
  typedef logic [7:0] esp_byte_t;
  typedef enum logic [1:0] {
    ESP_REG_NONE,
    ESP_REG_DATA,
    ESP_REG_DIR,
    ESP_REG_ASEL
  } esp_reg_e;
endpackage : esp_pkg

// ==== rtl/esp_sync2.sv ====
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module esp_sync2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk, // sampling clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // level from outside the clock domain
  output logic [WIDTH-1:0] sync_out // level safe to use in clk domain
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : esp_sync2
`default_nettype wire

// ==== rtl/esp_port.sv ====
// eight pin general purpose port with analog channel takeover, apb register slave
`timescale 1ns/1ps
`default_nettype none
`include "esp_consts.svh"
// Contract
// - Each of the eight pins has a data latch that software can write, and read back while the pin is an output.
// - Reset leaves the data latches untouched, so they hold old or undefined values.
// - A direction bit of 1 drives the pin and 0 leaves it an undriven input.
// - Reset clears all direction bits and software can read and write them.
// - For an output pin a data read returns that pin's latch bit.
// - For an input pin a data read returns the synchronised pin level.
// - Latch writes with byte strobe 0 set land whatever the direction and do not change what an input bit reads back.
// - A pin picked by the converter channel selection is forced to analog input.
// - Pins picked by neither the converter nor the software selection act as normal digital pins.
module esp_port
  import esp_pkg::*;
#(
  parameter int NUM_PINS = `ESP_NUM_PINS,
  parameter int ADDR_W = `ESP_ADDR_W
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error for unmapped address
  input wire logic [NUM_PINS-1:0] pin_in, // pin levels from the pads
  output logic [NUM_PINS-1:0] pin_out, // pad output values
  output logic [NUM_PINS-1:0] pin_oe, // pad output enables, high drives
  output logic [NUM_PINS-1:0] analog_connect, // routes a pad to the converter
  input wire logic adc_sel_valid, // converter channel selection names a port pin
  input wire logic [2:0] adc_sel_ch // converter channel index within the port
);
  localparam int PAD_W = 32 - NUM_PINS;

  // latch bits are deliberately not reset
  logic [NUM_PINS-1:0] latch_bits;
  logic [NUM_PINS-1:0] direction_bits;
  logic [3:0] analog_select_reg;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] analog_mask;
  logic [NUM_PINS-1:0] read_value;
  logic wr_en;
  logic rd_en;
  esp_reg_e sel_reg;

  // map a byte address onto one of the registers
  function automatic esp_reg_e esp_decode(input logic [ADDR_W-1:0] addr);
    esp_reg_e r;
    r = ESP_REG_NONE;
    if (addr == ADDR_W'(`ESP_DATA_ADDR)) begin
      r = ESP_REG_DATA;
    end else if (addr == ADDR_W'(`ESP_DIR_ADDR)) begin
      r = ESP_REG_DIR;
    end else if (addr == ADDR_W'(`ESP_ASEL_ADDR)) begin
      r = ESP_REG_ASEL;
    end
    return r;
  endfunction : esp_decode

  // pad levels come from outside the clock domain
  esp_sync2 #(
    .WIDTH(NUM_PINS)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // zero wait-state slave; accesses end in the first access cycle
  assign sel_reg = esp_decode(paddr);
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && (sel_reg == ESP_REG_NONE);

  // data latch: written regardless of direction, never reset
  always_ff @(posedge pclk) begin
    if (wr_en && sel_reg == ESP_REG_DATA && pstrb[0]) begin
      latch_bits <= pwdata[NUM_PINS-1:0];
    end
  end

  // direction bits clear on reset so every pin starts as input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direction_bits <= NUM_PINS'(`ESP_DIR_RESET);
    end else if (wr_en && sel_reg == ESP_REG_DIR && pstrb[0]) begin
      direction_bits <= pwdata[NUM_PINS-1:0];
    end
  end

  // software analog channel selection: enable bit and channel index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_select_reg <= 4'(`ESP_ASEL_RESET);
    end else if (wr_en && sel_reg == ESP_REG_ASEL && pstrb[0]) begin
      analog_select_reg <= pwdata[`ESP_ASEL_EN_BIT:`ESP_ASEL_CH_LSB];
    end
  end

  // per pin takeover by either the converter or the software selection
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      assign analog_mask[g] = (adc_sel_valid && adc_sel_ch == 3'(g))
        || (analog_select_reg[`ESP_ASEL_EN_BIT]
        && analog_select_reg[`ESP_ASEL_CH_MSB:`ESP_ASEL_CH_LSB] == 3'(g));
      // output pins read the latch, input pins read the pad
      assign read_value[g] = direction_bits[g] ? latch_bits[g] : pin_sync[g];
    end
  endgenerate

  // pad controls are registered so writes show from the next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe <= '0;
      pin_out <= '0;
      analog_connect <= '0;
    end else begin
      pin_oe <= direction_bits & ~analog_mask;
      pin_out <= latch_bits & direction_bits & ~analog_mask;
      analog_connect <= analog_mask;
    end
  end

  // read data registered in the setup cycle, valid during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (sel_reg)
        ESP_REG_DATA: prdata <= {PAD_W'(0), read_value};
        ESP_REG_DIR: prdata <= {PAD_W'(0), direction_bits};
        ESP_REG_ASEL: prdata <= {28'h0000000, analog_select_reg};
        ESP_REG_NONE: prdata <= '0;
      endcase
    end
  end

  // rd_en kept for clarity of the read path timing
  logic unused_rd;
  assign unused_rd = rd_en;
endmodule : esp_port
`default_nettype wire

// ==== verif/esp_port_properties.sv ====
// assertion checker for the shared analog port
`timescale 1ns/1ps
`default_nettype none
`include "esp_consts.svh"
module esp_port_properties (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [13:0] paddr, // address
  input wire logic [31:0] prdata, // rdata
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [7:0] pin_out, // pad value
  input wire logic [7:0] pin_oe, // pad enable
  input wire logic [7:0] analog_connect, // analog route
  input wire logic adc_sel_valid, // pick valid
  input wire logic [2:0] adc_sel_ch // pick channel
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic bad;
  // access phase and unmapped address decode
  assign acc = psel && penable;
  assign bad = paddr != `ESP_DATA_ADDR && paddr != `ESP_DIR_ADDR && paddr != `ESP_ASEL_ADDR;
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err; pslverr == (acc && bad); endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_rd_bad; acc && !pwrite && bad |-> prdata == 32'h0; endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("unmapped data");
  property p_upper; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits");
  property p_oe_an; (pin_oe & analog_connect) == 8'h00; endproperty
  a_oe_an: assert property (p_oe_an) else $error("analog driven");
  property p_out_oe; (pin_out & ~pin_oe) == 8'h00; endproperty
  a_out_oe: assert property (p_out_oe) else $error("undriven value");
  property p_adc; adc_sel_valid |=> analog_connect[$past(adc_sel_ch)]; endproperty
  a_adc: assert property (p_adc) else $error("no analog");
  property p_rst; $rose(presetn) |-> pin_oe == 8'h00 && analog_connect == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_wr: cover property (acc && pwrite);
  c_err: cover property (pslverr);
  c_an: cover property (analog_connect != 8'h00);
endmodule : esp_port_properties
`default_nettype wire

// ==== verif/esp_pad_model.sv ====
// pad side model of the shared analog port
`timescale 1ns/1ps
`default_nettype none
module esp_pad_model (
  input wire logic [7:0] pin_out, // port value
  input wire logic [7:0] pin_oe, // port enable
  input wire logic [7:0] ext_level, // outside level
  output logic [7:0] pin_in // pad level
);
  // driven pads show the port value, the others the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : esp_pad_model
`default_nettype wire

// ==== verif/eight_bit_analog_shared_port_test.sv ====
// testbench of the shared analog port
`timescale 1ns/1ps
`default_nettype none
`include "esp_consts.svh"
module eight_bit_analog_shared_port_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic adc_sel_valid = 1'b0, pready, pslverr, e;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] adc_sel_ch = 3'h0;
  logic [7:0] pin_in, pin_out, pin_oe, analog_connect, ext_level = 8'h3C;
  int n_fail = 0, compares = 0;
  // clock
  always #12.5 pclk = ~pclk;
  esp_port esp_port_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .analog_connect,
    .adc_sel_valid, .adc_sel_ch);
  esp_pad_model esp_pad_model_inst (.pin_out, .pin_oe, .ext_level, .pin_in);
  // one apb transfer, read data lands in r
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, `ESP_DIR_ADDR, 32'h0);
    chk(r, 32'h0);
    xfer(1'b1, `ESP_DATA_ADDR, 32'hA5);
    xfer(1'b1, `ESP_DIR_ADDR, 32'h0F);
    xfer(1'b0, `ESP_DIR_ADDR, 32'h0);
    chk(r, 32'h0F);
    chk(32'(pin_oe), 32'h0F);
    chk(32'(pin_out), 32'h05);
    xfer(1'b0, `ESP_DATA_ADDR, 32'h0);
    chk(r, 32'h35);
    xfer(1'b1, `ESP_DATA_ADDR, 32'h5A);
    xfer(1'b0, `ESP_DATA_ADDR, 32'h0);
    chk(r, 32'h3A);
    xfer(1'b0, 14'h1110, 32'h0);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    xfer(1'b1, `ESP_ASEL_ADDR, 32'h9);
    xfer(1'b0, `ESP_ASEL_ADDR, 32'h0);
    chk(r, 32'h9);
    chk(32'(e), 32'h0);
    chk(32'(analog_connect), 32'h02);
    chk(32'(pin_oe), 32'h0D);
    xfer(1'b1, `ESP_ASEL_ADDR, 32'h0);
    // each converter pick routes that pin to analog; picks of the output pins 0 to 3 also drop their output enable
    adc_sel_valid <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      adc_sel_ch <= 3'(i);
      repeat (3) @(posedge pclk);
      chk(32'(analog_connect), 32'(8'h01 << i));
      chk(32'(pin_oe), 32'(8'h0F & ~(8'h01 << i)));
    end
    adc_sel_valid <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, `ESP_DIR_ADDR, 32'h0);
    chk(r, 32'h0);
    xfer(1'b1, `ESP_DIR_ADDR, 32'hFF);
    xfer(1'b0, `ESP_DATA_ADDR, 32'h0);
    chk(r, 32'h5A);
    wrap_up();
  end
  // watchdog
  initial begin
    repeat (2000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end
endmodule : eight_bit_analog_shared_port_test
bind esp_port esp_port_properties esp_port_properties_inst (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .pin_out, .pin_oe,
  .analog_connect, .adc_sel_valid, .adc_sel_ch);
`default_nettype wire
